// ===== hdl/ssr_sync_serial_port.sv
/*
 * ssr_sync_serial_port: register block, fifos and master frame engine of
 * a synchronous serial port.
 * assumes: clk is the separately enabled port peripheral clock; register
 * strobes are one cycle and synchronous; bus pins resolved outside.
 */
// Decided for this implementation: the strobed register port.
// What this block does
// - peripheral clock drives the serial prescaler
// - decode at one of two bases
// - offset 0x000 holds rate, type, length
// - offset 0x004 holds master/slave and modes
// - data write pushes tx, read pops rx
// - offset 0x014 sets, clears each mask bit
// - raw status read-only, resets to 0x8
// - masked status read-only, resets to zero
// - clear register clears written interrupt bits
// - frame length is length field plus one
// - reset values cover implemented bits only
// - bit rate from prescale and divider
// - frame type selects spi, sync, wire
// - spi idle clock level from polarity bit
// - spi capture edge from phase bit
`timescale 1ns/1ps
`default_nettype none
module ssr_sync_serial_port
    import ssr_pkg::*;
#(
    parameter logic PORT_SEL = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        miso_i,
    output ssr_pins_s        pins,
    output logic             irq
);

    localparam logic [31:0] BASE = PORT_SEL ? BASE_PORT1 : BASE_PORT0;

    ssr_state_s st_ff;
    ssr_state_s nxt_st;

    function automatic logic hit(input logic [31:0] a,
                                 input logic [11:0] ofs);
        hit = (a[31:PAGE_LSB] == BASE[31:PAGE_LSB])
              && (a[PAGE_LSB-1:0] == ofs);
    endfunction

    logic [3:0]        len_code;
    logic [1:0]        ftype;
    logic              is_spi;
    logic              pol;
    logic              pha;
    logic [7:0]        rate_max;
    logic [6:0]        pre_max;
    logic              tick;
    logic              lead;
    logic              sample_now;
    logic              rx_bit;
    logic [WORD_W-1:0] len_mask;
    logic              idle_sel;
    logic              engine_on;

    always_comb begin
        len_code  = st_ff.cr0[LEN_MSB:LEN_LSB];
        ftype     = st_ff.cr0[TYPE_MSB:TYPE_LSB];
        is_spi    = (ftype == TYPE_SPI);
        pol       = is_spi & st_ff.cr0[POL_BIT];
        pha       = is_spi & st_ff.cr0[PHA_BIT];
        rate_max  = st_ff.cr0[RATE_MSB:RATE_LSB];
        // an odd or tiny prescale still yields a usable half-bit period
        pre_max   = (st_ff.cps < 8'h02) ? 7'h00
                                        : (st_ff.cps[7:1] - 7'h01);
        tick      = (st_ff.pre == pre_max) && (st_ff.rate == rate_max);
        lead      = ~st_ff.half[0];
        sample_now = lead ? ~pha : pha;
        rx_bit    = st_ff.cr1[LOOP_BIT] ? st_ff.pins.mosi : miso_i;
        len_mask  = 16'hffff >> (LEN_TOP - len_code);
        idle_sel  = (ftype != TYPE_SYNC);
        engine_on = st_ff.cr1[ENABLE_BIT] & ~st_ff.cr1[SLAVE_BIT];
    end

    logic              tx_push;
    logic              tx_pop;
    logic              rx_push;
    logic              rx_pop;
    logic              ovr_ev;
    logic [WORD_W-1:0] rx_word;
    logic [WORD_W-1:0] tx_word;
    logic [IRQ_W-1:0]  set_ev;
    logic [IRQ_W-1:0]  clr_bits;
    logic [STATUS_W-1:0] status;

    always_comb begin
        nxt_st   = st_ff;
        nxt_st.rdata = '0;
        tx_push  = 1'b0;
        tx_pop   = 1'b0;
        rx_push  = 1'b0;
        rx_pop   = 1'b0;
        ovr_ev   = 1'b0;
        rx_word  = '0;
        tx_word  = st_ff.txq[st_ff.tx_rp];
        clr_bits = '0;
        status   = '0;
        status[ST_TX_EMPTY] = (st_ff.tx_cnt == '0);
        status[ST_TX_ROOM]  = (st_ff.tx_cnt != CNT_FULL);
        status[ST_RX_AVAIL] = (st_ff.rx_cnt != '0);
        status[ST_RX_FULL]  = (st_ff.rx_cnt == CNT_FULL);
        status[ST_BUSY]     = (st_ff.phase != ST_IDLE);

        // register writes
        if (wr) begin
            if (hit(addr, OFS_FRAME_RATE)) begin
                nxt_st.cr0 = wdata[CR0_W-1:0];
            end
            if (hit(addr, OFS_MODE)) begin
                nxt_st.cr1[LOOP_BIT]   = wdata[LOOP_BIT];
                nxt_st.cr1[ENABLE_BIT] = wdata[ENABLE_BIT];
                nxt_st.cr1[SOD_BIT]    = wdata[SOD_BIT];
                // role may only change while the port is disabled
                if (!st_ff.cr1[ENABLE_BIT]) begin
                    nxt_st.cr1[SLAVE_BIT] = wdata[SLAVE_BIT];
                end
            end
            if (hit(addr, OFS_DATA) && st_ff.tx_cnt != CNT_FULL) begin
                tx_push = 1'b1;
            end
            if (hit(addr, OFS_PRESCALE)) begin
                nxt_st.cps = {wdata[7:1], 1'b0};
            end
            if (hit(addr, OFS_IRQ_MASK)) begin
                nxt_st.mask = wdata[IRQ_W-1:0];
            end
            if (hit(addr, OFS_IRQ_CLEAR)) begin
                clr_bits = wdata[IRQ_W-1:0];
            end
        end

        // register reads; data stands only in the following cycle
        if (rd) begin
            if (hit(addr, OFS_FRAME_RATE)) begin
                nxt_st.rdata = {16'h0000, st_ff.cr0};
            end
            if (hit(addr, OFS_MODE)) begin
                nxt_st.rdata = {28'h0000000, st_ff.cr1};
            end
            if (hit(addr, OFS_DATA) && st_ff.rx_cnt != '0) begin
                rx_pop = 1'b1;
                nxt_st.rdata = {16'h0000, st_ff.rxq[st_ff.rx_rp]};
            end
            if (hit(addr, OFS_STATUS)) begin
                nxt_st.rdata = {27'h0000000, status};
            end
            if (hit(addr, OFS_PRESCALE)) begin
                nxt_st.rdata = {24'h000000, st_ff.cps};
            end
            if (hit(addr, OFS_IRQ_MASK)) begin
                nxt_st.rdata = {28'h0000000, st_ff.mask};
            end
            if (hit(addr, OFS_IRQ_RAW)) begin
                nxt_st.rdata = {28'h0000000, st_ff.raw};
            end
            if (hit(addr, OFS_IRQ_MSK_ST)) begin
                nxt_st.rdata = {28'h0000000,
                                st_ff.raw & st_ff.mask};
            end
        end

        // half-bit timebase, counts only while the engine is out of idle (shift and gap)
        if (st_ff.phase == ST_IDLE) begin
            nxt_st.pre  = '0;
            nxt_st.rate = '0;
        end else if (tick) begin
            nxt_st.pre  = '0;
            nxt_st.rate = '0;
        end else if (st_ff.pre == pre_max) begin
            nxt_st.pre  = '0;
            nxt_st.rate = st_ff.rate + 8'h01;
        end else begin
            nxt_st.pre  = st_ff.pre + 7'h01;
        end

        // frame engine (master role)
        unique case (st_ff.phase)
            ST_IDLE: begin
                nxt_st.pins.sck = pol;
                nxt_st.pins.sel = idle_sel;
                if (engine_on && st_ff.tx_cnt != '0) begin
                    tx_pop          = 1'b1;
                    nxt_st.phase    = ST_SHIFT;
                    nxt_st.half     = '0;
                    nxt_st.rsh      = '0;
                    nxt_st.pins.sel = ~idle_sel;
                    nxt_st.pins.mosi = tx_word[len_code];
                    // phase 0 presents the first bit before the first edge
                    nxt_st.tsh = pha ? tx_word : (tx_word << 1);
                end
            end
            ST_SHIFT: begin
                if (tick) begin
                    nxt_st.pins.sck = ~st_ff.pins.sck;
                    nxt_st.half     = st_ff.half + 5'h01;
                    if (ftype == TYPE_SYNC && st_ff.half == 5'h00) begin
                        nxt_st.pins.sel = 1'b0;
                    end
                    if (sample_now) begin
                        nxt_st.rsh = {st_ff.rsh[WORD_W-2:0], rx_bit};
                    end else begin
                        nxt_st.pins.mosi = st_ff.tsh[len_code];
                        nxt_st.tsh       = st_ff.tsh << 1;
                    end
                    if (st_ff.half == {len_code, 1'b1}) begin
                        nxt_st.phase    = ST_GAP;
                        nxt_st.pins.sel = idle_sel;
                        rx_word = nxt_st.rsh & len_mask;
                        if (st_ff.rx_cnt == CNT_FULL) begin
                            ovr_ev = 1'b1;
                        end else begin
                            rx_push = 1'b1;
                        end
                    end
                end
            end
            ST_GAP: begin
                if (tick) begin
                    nxt_st.phase = ST_IDLE;
                end
            end
        endcase

        // fifo bookkeeping
        if (tx_push) begin
            nxt_st.txq[st_ff.tx_wp] = wdata[WORD_W-1:0];
            nxt_st.tx_wp = st_ff.tx_wp + 3'h1;
        end
        if (tx_pop) begin
            nxt_st.tx_rp = st_ff.tx_rp + 3'h1;
        end
        nxt_st.tx_cnt = st_ff.tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop};
        if (rx_push) begin
            nxt_st.rxq[st_ff.rx_wp] = rx_word;
            nxt_st.rx_wp = st_ff.rx_wp + 3'h1;
        end
        if (rx_pop) begin
            nxt_st.rx_rp = st_ff.rx_rp + 3'h1;
        end
        nxt_st.rx_cnt = st_ff.rx_cnt + {3'h0, rx_push} - {3'h0, rx_pop};

        // sticky events: a set in the clearing cycle wins
        set_ev = '0;
        set_ev[IRQ_OVERRUN] = ovr_ev;
        set_ev[IRQ_RX_HALF] = (st_ff.rx_cnt >= CNT_HALF);
        set_ev[IRQ_TX_HALF] = (st_ff.tx_cnt <= CNT_HALF);
        nxt_st.raw = (st_ff.raw & ~clr_bits) | set_ev;
        nxt_st.irq = |(nxt_st.raw & nxt_st.mask);

        nxt_st.pins.sck_oe  = engine_on;
        nxt_st.pins.sel_oe  = engine_on;
        nxt_st.pins.mosi_oe = engine_on;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_ff <= STATE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata = st_ff.rdata;
    assign pins  = st_ff.pins;
    assign irq   = st_ff.irq;

    // helper for checking the half-bit period
    logic [15:0] gap_ff;
    always_ff @(posedge clk) begin
        if (!rstn || st_ff.phase == ST_IDLE || tick) begin
            gap_ff <= 16'h0000;
        end else begin
            gap_ff <= gap_ff + 16'h0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_reset_vals;
        !$past(rstn) |-> st_ff.raw == RAW_RST && st_ff.mask == '0
                         && st_ff.cr0 == '0 && !irq;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values of registers wrong");

    property p_masked_read;
        rd && hit(addr, OFS_IRQ_MSK_ST)
            |=> rdata == {28'h0000000, $past(st_ff.raw & st_ff.mask)};
    endproperty
    a_masked_read: assert property (p_masked_read)
        else $error("masked status read does not equal raw and mask");

    property p_irq_level;
        ##1 irq == |(st_ff.raw & st_ff.mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt output disagrees with masked status");

    property p_data_push;
        wr && hit(addr, OFS_DATA) && st_ff.tx_cnt != CNT_FULL && !tx_pop
            |=> st_ff.tx_cnt == $past(st_ff.tx_cnt) + 4'h1;
    endproperty
    a_data_push: assert property (p_data_push)
        else $error("data write did not enter the transmit fifo");

    property p_data_pop;
        rd && hit(addr, OFS_DATA) && st_ff.rx_cnt != '0
            && st_ff.phase != ST_SHIFT
            |=> st_ff.rx_cnt == $past(st_ff.rx_cnt) - 4'h1
                && rdata[WORD_W-1:0] == $past(st_ff.rxq[st_ff.rx_rp]);
    endproperty
    a_data_pop: assert property (p_data_pop)
        else $error("data read did not pop the receive fifo");

    property p_clear_bit;
        wr && hit(addr, OFS_IRQ_CLEAR) && wdata[IRQ_OVERRUN] && !ovr_ev
            |=> !st_ff.raw[IRQ_OVERRUN];
    endproperty
    a_clear_bit: assert property (p_clear_bit)
        else $error("written clear bit left the overrun flag set");

    property p_role_locked;
        wr && hit(addr, OFS_MODE) && st_ff.cr1[ENABLE_BIT]
            |=> $stable(st_ff.cr1[SLAVE_BIT]);
    endproperty
    a_role_locked: assert property (p_role_locked)
        else $error("role changed while port enabled");

    property p_idle_clock;
        st_ff.phase == ST_IDLE ##1 st_ff.phase == ST_IDLE
            |-> pins.sck == $past(pol);
    endproperty
    a_idle_clock: assert property (p_idle_clock)
        else $error("idle clock level differs from polarity");

    property p_frame_len;
        st_ff.phase == ST_SHIFT && tick && st_ff.half == {len_code, 1'b1}
            |=> st_ff.phase == ST_GAP && pins.sck == $past(pol);
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame did not end after length plus one bits");

    property p_bit_rate;
        st_ff.phase != ST_IDLE && tick
            |-> gap_ff + 16'h0001
                == 16'((st_ff.cps < 8'h02) ? 8'h01 : {1'b0, st_ff.cps[7:1]})
                * 16'({1'b0, st_ff.cr0[RATE_MSB:RATE_LSB]} + 9'h001);
    endproperty
    a_bit_rate: assert property (p_bit_rate)
        else $error("half-bit period differs from prescale times rate");

endmodule // ssr_sync_serial_port
`default_nettype wire

// ===== hdl/ssr_pkg.sv
/*
 * ssr_pkg: register map, field layout, reset values and state record of
 * the synchronous serial port register block.
 * assumes: one 25 MHz clock that also clocks the serial prescaler.
 */
`default_nettype none
package ssr_pkg;

    // instance decode bases, offsets identical in both instances
    localparam logic [31:0] BASE_PORT0 = 32'h4004_0000;
    localparam logic [31:0] BASE_PORT1 = 32'h4005_8000;
    localparam int          PAGE_LSB   = 12;

    localparam logic [11:0] OFS_FRAME_RATE = 12'h000;
    localparam logic [11:0] OFS_MODE       = 12'h004;
    localparam logic [11:0] OFS_DATA       = 12'h008;
    localparam logic [11:0] OFS_STATUS     = 12'h00c;
    localparam logic [11:0] OFS_PRESCALE   = 12'h010;
    localparam logic [11:0] OFS_IRQ_MASK   = 12'h014;
    localparam logic [11:0] OFS_IRQ_RAW    = 12'h018;
    localparam logic [11:0] OFS_IRQ_MSK_ST = 12'h01c;
    localparam logic [11:0] OFS_IRQ_CLEAR  = 12'h020;

    // frame_and_rate_control fields
    localparam int LEN_LSB  = 0;
    localparam int LEN_MSB  = 3;
    localparam int TYPE_LSB = 4;
    localparam int TYPE_MSB = 5;
    localparam int POL_BIT  = 6;
    localparam int PHA_BIT  = 7;
    localparam int RATE_LSB = 8;
    localparam int RATE_MSB = 15;
    localparam int CR0_W    = 16;

    localparam logic [1:0] TYPE_SPI  = 2'h0;
    localparam logic [1:0] TYPE_SYNC = 2'h1;
    localparam logic [1:0] TYPE_WIRE = 2'h2;

    // mode_control fields
    localparam int LOOP_BIT   = 0;
    localparam int ENABLE_BIT = 1;
    localparam int SLAVE_BIT  = 2;
    localparam int SOD_BIT    = 3;
    localparam int CR1_W      = 4;

    // interrupt bits, shared by mask, raw, masked and clear registers
    localparam int         IRQ_OVERRUN = 0;
    localparam int         IRQ_RX_HALF = 2;
    localparam int         IRQ_TX_HALF = 3;
    localparam int         IRQ_W       = 4;
    localparam logic [3:0] RAW_RST     = 4'h8;

    // port_status bits
    localparam int         ST_TX_EMPTY  = 0;
    localparam int         ST_TX_ROOM   = 1;
    localparam int         ST_RX_AVAIL  = 2;
    localparam int         ST_RX_FULL   = 3;
    localparam int         ST_BUSY      = 4;
    localparam int         STATUS_W     = 5;
    localparam logic [4:0] STATUS_RST   = 5'h03;

    localparam int         PRESCALE_W   = 8;
    localparam int         WORD_W       = 16;
    localparam int         DEPTH        = 8;
    localparam int         PTR_W        = 3;
    localparam int         CNT_W        = 4;
    localparam logic [3:0] CNT_FULL     = 4'h8;
    localparam logic [3:0] CNT_HALF     = 4'h4;
    localparam logic [3:0] LEN_TOP      = 4'hf;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_GAP   = 3'b100
    } ssr_phase_e;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic sel;
        logic sel_oe;
        logic mosi;
        logic mosi_oe;
    } ssr_pins_s;

    typedef struct packed {
        logic [CR0_W-1:0]                 cr0;
        logic [CR1_W-1:0]                 cr1;
        logic [PRESCALE_W-1:0]            cps;
        logic [IRQ_W-1:0]                 mask;
        logic [IRQ_W-1:0]                 raw;
        logic [DEPTH-1:0][WORD_W-1:0]     txq;
        logic [PTR_W-1:0]                 tx_wp;
        logic [PTR_W-1:0]                 tx_rp;
        logic [CNT_W-1:0]                 tx_cnt;
        logic [DEPTH-1:0][WORD_W-1:0]     rxq;
        logic [PTR_W-1:0]                 rx_wp;
        logic [PTR_W-1:0]                 rx_rp;
        logic [CNT_W-1:0]                 rx_cnt;
        ssr_phase_e                       phase;
        logic [6:0]                       pre;
        logic [7:0]                       rate;
        logic [4:0]                       half;
        logic [WORD_W-1:0]                tsh;
        logic [WORD_W-1:0]                rsh;
        logic [31:0]                      rdata;
        logic                             irq;
        ssr_pins_s                        pins;
    } ssr_state_s;

    localparam ssr_state_s STATE_RST = '{
        raw:   RAW_RST,
        phase: ST_IDLE,
        pins:  '{sel: 1'b1, default: 1'b0},
        default: '0
    };

endpackage
`default_nettype wire

// ===== tb/ssr_slave_model.sv
/*
 * ssr_slave_model: behavioural serial slave facing the port's master pins.
 * assumes: half-bit period of two clocks or more; reply loaded while idle.
 */
`timescale 1ns/1ps
`default_nettype none
module ssr_slave_model
    import ssr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire ssr_pins_s   pins,
    input  wire logic        pol,
    input  wire logic        pha,
    input  wire logic [4:0]  len,
    input  wire logic [15:0] reply,
    output logic             miso,
    output logic      [15:0] got
);
    logic        sck_q;
    logic        sel_q;
    logic        begun;
    logic        tog;
    logic [15:0] sh;
    logic        lead;
    logic        trail;
    assign lead  = (sck_q == pol) && (pins.sck != pol);
    assign trail = (sck_q != pol) && (pins.sck == pol);
    // unselected line shows a changing pattern, never the last bit
    assign miso  = pins.sel ? tog : sh[len-5'd1];
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sck_q <= 1'b0;
            sel_q <= 1'b1;
            begun <= 1'b0;
            tog   <= 1'b0;
            sh    <= '0;
            got   <= '0;
        end else begin
            sck_q <= pins.sck;
            sel_q <= pins.sel;
            tog   <= ~tog;
            // the last capture edge can meet the deselect in one cycle
            if ((!pins.sel || !sel_q) && (pha ? trail : lead))
                got <= {got[14:0], pins.mosi};
            if (pins.sel) begin
                sh    <= reply;
                begun <= 1'b0;
            end else begin
                if (lead)
                    begun <= 1'b1;
                if (pha ? (lead && begun) : trail)
                    sh <= {sh[14:0], 1'b0};
            end
        end
    end
endmodule // ssr_slave_model
`default_nettype wire

// ===== tb/sync_serial_port_regs_bench.sv
/*
 * sync_serial_port_regs_bench: self-checking bench of the port registers.
 * assumes: port instance at the first base; slave model on the pins.
 */
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_regs_bench;
    import ssr_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        pol = 1'b0, pha = 1'b0, miso, irq;
    logic        sck_q = 1'b0, sel_q = 1'b1, fval = 1'b0, loop = 1'b0;
    logic [31:0] addr = '0, wdata = '0, rdata, d;
    logic [4:0]  len = 5'h8;
    logic [15:0] reply = '0, got;
    logic [15:0] expq[$];
    ssr_pins_s   pins;
    int          err_count = 0, total_checks = 0, edges = 0;
    int          e0 = 0, sel_chg = 0, sel_mark = 0;
    logic [31:0] rst_exp [10] = '{32'h0, 32'h0, 32'h0, 32'h3, 32'h0,
                                  32'h0, 32'h8, 32'h0, 32'h0, 32'h0};

    ssr_sync_serial_port #(.PORT_SEL(1'b0)) uut (.clk(clk), .rstn(rstn),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .miso_i(miso), .pins(pins), .irq(irq));
    ssr_slave_model peer (.clk(clk), .rstn(rstn), .pins(pins), .pol(pol),
        .pha(pha), .len(len), .reply(reply), .miso(miso), .got(got));

    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        if (pins.sck !== sck_q)
            edges <= edges + 1;
        // only the first select change after the mark is kept
        if (pins.sel !== sel_q) begin
            sel_chg <= sel_chg + 1;
            if (sel_chg == sel_mark)
                fval <= pins.sel;
        end
        sck_q <= pins.sck;
        sel_q <= pins.sel;
    end

    task automatic conclude;
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [31:0] ra(input logic [11:0] o);
        return BASE_PORT0 + {20'h0, o};
    endfunction
    function automatic logic [31:0] oe();
        return {29'h0, pins.sck_oe, pins.sel_oe, pins.mosi_oe};
    endfunction
    function automatic logic [15:0] fit(input logic [15:0] w,
                                        input logic [3:0] c);
        return w & ((16'h1 << (5'(c) + 5'd1)) - 16'h1);
    endfunction
    function automatic logic [3:0] rc();
        return 4'(3 + $urandom % 13); // codes below three avoided
    endfunction
    task automatic bw(input logic [31:0] a, v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic br(input logic [31:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic rchk(input string n, input logic [11:0] o,
                        input logic [31:0] e);
        br(ra(o));
        chk(n, e, d);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 3000; i++) begin
            br(ra(OFS_STATUS));
            if (d[ST_BUSY] === 1'b0 && d[ST_TX_EMPTY] === 1'b1)
                break;
            if (i == 2999) begin
                err_count++;
                conclude();
            end
        end
        // busy stays set until the gap half-bit ends
        repeat (8) @(posedge clk);
    endtask
    task automatic frame(input logic p, h, input logic [1:0] t,
                         input logic [3:0] c);
        logic [15:0] w;
        w = 16'($urandom);
        @(posedge clk);
        pol   <= p;
        pha   <= h;
        len   <= 5'(c) + 5'd1;
        reply <= 16'($urandom);
        bw(ra(OFS_FRAME_RATE), {16'h0, 8'h01, h, p, t, c});
        repeat (3) @(posedge clk);
        @(negedge clk);
        e0       = edges;
        sel_mark = sel_chg;
        bw(ra(OFS_DATA), {16'h0, w});
        wait_idle();
        chk("sck edges", 32'(2 * (c + 1)), 32'(edges - e0));
        chk("idle sck", {31'h0, p}, {31'h0, pins.sck});
        chk("sel lead", {31'h0, t == TYPE_SYNC}, {31'h0, fval});
        if (t != TYPE_SYNC) begin
            chk("mosi", {16'h0, fit(w, c)}, {16'h0, fit(got, c)});
            // loopback hears its own transmit line
            expq.push_back(loop ? fit(w, c) : fit(reply, c));
        end
    endtask

    initial begin
        logic [31:0] v;
        void'($urandom(72));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 10; i++)
            rchk("reset", 12'(i * 4), rst_exp[i]);
        br(BASE_PORT1 + {20'h0, OFS_IRQ_RAW});
        chk("other base", 32'h0, d);
        v = {16'h0, 8'($urandom), 2'($urandom), 2'($urandom % 3), rc()};
        bw(ra(OFS_FRAME_RATE), v);
        rchk("frame control", OFS_FRAME_RATE, v);
        v = 32'($urandom) & 32'hd;
        bw(ra(OFS_MODE), v);
        rchk("mode", OFS_MODE, v);
        v = 32'($urandom);
        bw(ra(OFS_PRESCALE), v);
        rchk("prescale", OFS_PRESCALE, v & 32'hfe);
        bw(ra(OFS_IRQ_MASK), 32'h8);
        rchk("masked", OFS_IRQ_MSK_ST, 32'h8);
        chk("irq", 32'h1, {31'h0, irq});
        bw(ra(OFS_IRQ_MASK), 32'h0);
        rchk("masked", OFS_IRQ_MSK_ST, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        bw(ra(OFS_PRESCALE), 32'h2);
        bw(ra(OFS_MODE), 32'h2);
        bw(ra(OFS_MODE), 32'h6);
        rchk("mode", OFS_MODE, 32'h2);
        chk("pin drive", 32'h7, oe());
        frame(1'b0, 1'b0, TYPE_SPI, 4'h3);
        frame(1'b1, 1'b0, TYPE_SPI, 4'hf);
        frame(1'b0, 1'b1, TYPE_SPI, rc());
        frame(1'b1, 1'b1, TYPE_SPI, rc());
        frame(1'b0, 1'b0, TYPE_WIRE, rc());
        bw(ra(OFS_MODE), 32'h3);
        loop = 1'b1;
        frame(1'b0, 1'b1, TYPE_SPI, rc());
        loop = 1'b0;
        bw(ra(OFS_MODE), 32'h2);
        rchk("raw", OFS_IRQ_RAW, 32'hc);
        bw(ra(OFS_IRQ_MASK), 32'h4);
        rchk("masked", OFS_IRQ_MSK_ST, 32'h4);
        chk("irq", 32'h1, {31'h0, irq});
        foreach (expq[k])
            rchk("rx word", OFS_DATA, {16'h0, expq[k]});
        rchk("rx empty", OFS_DATA, 32'h0);
        bw(ra(OFS_IRQ_CLEAR), 32'h4);
        rchk("raw", OFS_IRQ_RAW, 32'h8);
        chk("irq", 32'h0, {31'h0, irq});
        frame(1'b0, 1'b0, TYPE_SYNC, rc());
        // one word already queued, so the eighth frame finds rx full
        for (int k = 0; k < 8; k++)
            frame(1'b1, 1'b0, TYPE_SPI, rc());
        rchk("overrun", OFS_IRQ_RAW, 32'hd);
        bw(ra(OFS_IRQ_CLEAR), 32'h1);
        rchk("raw", OFS_IRQ_RAW, 32'hc);
        bw(ra(OFS_MODE), 32'h0);
        bw(ra(OFS_MODE), 32'h6);
        rchk("mode", OFS_MODE, 32'h6);
        chk("pin drive", 32'h0, oe());
        conclude();
    end
endmodule // sync_serial_port_regs_bench
`default_nettype wire
